// ===== common/ssfc_pkg.sv
// Shared constants and types for the sensorless startup and fault block
package ssfc_pkg;

    // Clock and time base
    localparam int unsigned CLK_HZ         = 50000000;
    localparam int unsigned MS_PER_S       = 1000;
    localparam int unsigned CYC_PER_MS     = CLK_HZ / 1000;

    // Parameter register widths
    localparam int unsigned MS_W    = 16;
    localparam int unsigned RPM_W   = 16;
    localparam int unsigned MV_W    = 16;
    localparam int unsigned BLANK_W = 8;
    localparam int unsigned TEMP_W  = 7;
    localparam int unsigned TO_W    = 32;
    localparam int unsigned DUTY_W  = 16;
    localparam int unsigned FAULT_W = 8;

    // Reset values of programmable parameters
    localparam logic [MS_W-1:0]    HOLD_MS_RST     = 16'h03E8;
    localparam logic [BLANK_W-1:0] BLANK_RST       = 8'h03;
    localparam logic [RPM_W-1:0]   BEGIN_RPM_RST   = 16'h0190;
    localparam logic [RPM_W-1:0]   END_RPM_RST     = 16'h03E8;
    localparam logic [MV_W-1:0]    BEGIN_MV_RST    = 16'h04B0;
    localparam logic [MV_W-1:0]    END_MV_RST      = 16'h0E10;
    localparam logic [MS_W-1:0]    RAMP_MS_RST     = 16'h01F4;
    localparam logic [MV_W-1:0]    SPIN_THR_RST    = 16'h01F4;
    localparam logic [TO_W-1:0]    TCP_TO_RST      = 32'h0000000A;
    localparam logic [TEMP_W-1:0]  TEMP_LIMIT_RST  = 7'h55;
    localparam logic               LOCAL_EN_RST    = 1'b1;

    // Fault bit positions
    localparam int unsigned FLT_ESTOP  = 0;
    localparam int unsigned FLT_UNDERV = 1;
    localparam int unsigned FLT_OVERV  = 2;
    localparam int unsigned FLT_UNDERI = 3;
    localparam int unsigned FLT_OVERI  = 4;
    localparam int unsigned FLT_WDOG   = 5;
    localparam int unsigned FLT_TEMP   = 6;
    localparam int unsigned FLT_STALL  = 7;

    // Run-state encoding
    localparam logic [1:0] RUN_STOPPED = 2'h0;
    localparam logic [1:0] RUN_RUNNING = 2'h1;
    localparam logic [1:0] RUN_ACCEL   = 2'h2;
    localparam logic [1:0] RUN_DECEL   = 2'h3;

    // Startup sequencer states, one-hot
    typedef enum logic [4:0] {
        SS_IDLE  = 5'b00001,
        SS_SPIN  = 5'b00010,
        SS_HOLD  = 5'b00100,
        SS_RAMP  = 5'b01000,
        SS_CLOSE = 5'b10000
    } ssfc_state_t;

endpackage : ssfc_pkg

// ===== logic/ssfc_top.sv
// Sensorless startup sequencer, fault latch and run-state logic
//
// What this block does
// - Hold rotor in start state for hold_time_ms
// - Blank zero-cross search for programmed PWM periods
// - Open loop begins at open_loop_begin_rpm
// - Open loop ends at open_loop_end_rpm
// - Apply begin voltage as duty at start
// - Apply end voltage as duty at end
// - Ramp voltage and speed over ramp time
// - After ramp switch to back-EMF closed loop
// - Wait while back-EMF above spin-down threshold
// - Drop idle TCP link after timeout seconds
// - Fault word bit layout, eight faults
// - Fault bits latch until cleared
// - Any write to fault word clears all
// - Drive inhibited while any fault set
// - Overtemperature sets fault, immediate shutdown
// - Run state reports stopped/run/accel; decel is never reported
// - Local controls act only when enabled
// - Ethernet commands need no enable; start refused while a fault is set
// - Read-only 16-bit firmware version
`timescale 1ns/1ps
`default_nettype none

module ssfc_top
    import ssfc_pkg::*;
#(
    // Arbitrary value, replaced at build time
    parameter logic [15:0] FW_VERSION = 16'h0001
) (
    input  wire logic                          clk,
    input  wire logic                          rst_b,
    // Parameters written by the host
    input  wire logic [ssfc_pkg::MS_W-1:0]     hold_time_ms,
    input  wire logic [ssfc_pkg::BLANK_W-1:0]  zero_cross_blank_periods,
    input  wire logic [ssfc_pkg::RPM_W-1:0]    open_loop_begin_rpm,
    input  wire logic [ssfc_pkg::RPM_W-1:0]    open_loop_end_rpm,
    input  wire logic [ssfc_pkg::MV_W-1:0]     open_loop_begin_mv,
    input  wire logic [ssfc_pkg::MV_W-1:0]     open_loop_end_mv,
    input  wire logic [ssfc_pkg::MS_W-1:0]     open_loop_ramp_ms,
    input  wire logic [ssfc_pkg::MV_W-1:0]     spin_down_threshold_mv,
    input  wire logic [ssfc_pkg::TO_W-1:0]     tcp_idle_timeout_s,
    input  wire logic [ssfc_pkg::TEMP_W-1:0]   temp_limit_c,
    input  wire logic                          local_control_enable,
    // Fault word access
    input  wire logic                          fault_flags_wr,
    output logic [ssfc_pkg::FAULT_W-1:0]       fault_flags,
    output logic [1:0]                         drive_run_state,
    output logic [15:0]                        fw_version_number,
    // Motor commands
    input  wire logic                          eth_start,
    input  wire logic                          eth_stop,
    input  wire logic                          local_start,
    input  wire logic                          local_stop,
    // Measurements, same clock domain
    input  wire logic [ssfc_pkg::MV_W-1:0]     back_emf_mv,
    input  wire logic [ssfc_pkg::MV_W-1:0]     bus_mv,
    input  wire logic [ssfc_pkg::TEMP_W-1:0]   ambient_c,
    input  wire logic [ssfc_pkg::FAULT_W-1:0]  fault_events,
    // PWM and commutation interface
    input  wire logic                          pwm_period_tick,
    input  wire logic                          commutate_done,
    input  wire logic                          link_activity,
    output logic                               drive_enable,
    output logic [ssfc_pkg::DUTY_W-1:0]        pwm_duty,
    output logic [ssfc_pkg::RPM_W-1:0]         commutation_rpm,
    output logic                               closed_loop,
    output logic                               zero_cross_search,
    output logic                               tcp_drop
);
    import ssfc_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Millisecond and second ticks
    logic [15:0] ms_div_r;
    logic [9:0]  s_div_r;
    wire         ms_tick = (ms_div_r == 16'(CYC_PER_MS - 1));
    wire         s_tick  = ms_tick && (s_div_r == 10'(MS_PER_S - 1));

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            ms_div_r <= 16'h0000;
            s_div_r  <= 10'h000;
        end else begin
            ms_div_r <= ms_tick ? 16'h0000 : ms_div_r + 16'h0001;
            if (s_tick)
                s_div_r <= 10'h000;
            else if (ms_tick)
                s_div_r <= s_div_r + 10'h001;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Fault latch
    logic [FAULT_W-1:0] fault_r;
    wire over_temp = (ambient_c > temp_limit_c);
    wire [FAULT_W-1:0] fault_set =
        fault_events | (FAULT_W'(over_temp) << FLT_TEMP);

    // any write clears; new events win
    always_ff @(posedge clk) begin
        if (!rst_b)
            fault_r <= '0;
        else
            fault_r <= (fault_flags_wr ? '0 : fault_r) | fault_set;
    end
    assign fault_flags = fault_r;

    // any fault (or one arriving) inhibits drive
    wire inhibit = (|fault_r) || (|fault_set);

    ////////////////////////////////////////////////////////////////////////
    // Command selection
    // local controls gated by enable
    wire cmd_start = eth_start || (local_control_enable && local_start);
    wire cmd_stop  = eth_stop  || (local_control_enable && local_stop);

    ////////////////////////////////////////////////////////////////////////
    // Startup sequencer
    ssfc_state_t state_r;
    ssfc_state_t state_nxt;
    logic [MS_W-1:0] ms_cnt_r;
    logic [MV_W-1:0] volt_r;
    logic [RPM_W-1:0] rpm_r;
    logic [BLANK_W-1:0] blank_r;

    wire cnt_hit_hold = ms_tick && (ms_cnt_r + 16'h0001 >= hold_time_ms);
    wire cnt_hit_ramp = ms_tick
                     && (ms_cnt_r + 16'h0001 >= open_loop_ramp_ms);

    // Linear interpolation: begin + (end-begin)*t/T, signed span
    wire signed [17:0] v_span = 18'(open_loop_end_mv)
                              - 18'(open_loop_begin_mv);
    wire signed [17:0] r_span = 18'(open_loop_end_rpm)
                              - 18'(open_loop_begin_rpm);
    wire signed [35:0] v_prod = v_span * $signed({2'b00, ms_cnt_r});
    wire signed [35:0] r_prod = r_span * $signed({2'b00, ms_cnt_r});
    wire signed [35:0] ramp_t = $signed({20'h00000, open_loop_ramp_ms});
    // Divide only used on ms updates; kept combinational for simplicity
    wire signed [35:0] v_step = v_prod / ramp_t;
    wire signed [35:0] r_step = r_prod / ramp_t;
    wire [MV_W-1:0]  v_ramp = open_loop_begin_mv + MV_W'(v_step);
    wire [RPM_W-1:0] r_ramp = open_loop_begin_rpm + RPM_W'(r_step);

    // Next-state logic
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            SS_IDLE: begin
                if (cmd_start && !inhibit)
                    state_nxt = SS_SPIN;
            end
            SS_SPIN: begin
                if (back_emf_mv <= spin_down_threshold_mv)
                    state_nxt = SS_HOLD;
            end
            SS_HOLD: begin
                if (cnt_hit_hold)
                    state_nxt = SS_RAMP;
            end
            SS_RAMP: begin
                // ramp expiry hands over to closed loop
                if (cnt_hit_ramp)
                    state_nxt = SS_CLOSE;
            end
            SS_CLOSE: state_nxt = SS_CLOSE;
            default:  state_nxt = SS_IDLE;
        endcase
        // fault or stop aborts at once
        if (inhibit || cmd_stop)
            state_nxt = SS_IDLE;
    end

    always_ff @(posedge clk) begin
        if (!rst_b)
            state_r <= SS_IDLE;
        else
            state_r <= state_nxt;
    end

    // Millisecond counter restarts at each state change
    always_ff @(posedge clk) begin
        if (!rst_b)
            ms_cnt_r <= '0;
        else if (state_nxt != state_r)
            ms_cnt_r <= '0;
        else if (ms_tick && ms_cnt_r != 16'hFFFF)
            ms_cnt_r <= ms_cnt_r + 16'h0001;
    end

    // Voltage and speed set-points
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            volt_r <= '0;
            rpm_r  <= '0;
        end else if (state_nxt == SS_HOLD || state_nxt == SS_SPIN) begin
            volt_r <= open_loop_begin_mv;
            rpm_r  <= open_loop_begin_rpm;
        end else if (state_r == SS_RAMP && state_nxt == SS_CLOSE) begin
            volt_r <= open_loop_end_mv;
            rpm_r  <= open_loop_end_rpm;
        end else if (state_r == SS_RAMP && ms_tick) begin
            volt_r <= v_ramp;
            rpm_r  <= r_ramp;
        end else if (state_nxt == SS_IDLE) begin
            volt_r <= '0;
            rpm_r  <= '0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Duty conversion
    // duty = mv/bus, full scale if over
    wire [31:0] duty_num  = {volt_r, 16'h0000};
    wire [31:0] duty_den  = {16'h0000, bus_mv};
    wire [31:0] duty_quot = (bus_mv == 16'h0000) ? 32'hFFFFFFFF
                                                 : duty_num / duty_den;
    wire [DUTY_W-1:0] duty_sat =
        (volt_r >= bus_mv) ? 16'hFFFF : duty_quot[DUTY_W-1:0];

    always_ff @(posedge clk) begin
        if (!rst_b)
            pwm_duty <= '0;
        // stop or fault zeroes duty next edge
        else if (inhibit || cmd_stop
                 || state_r == SS_IDLE || state_r == SS_SPIN)
            pwm_duty <= '0;
        else
            pwm_duty <= duty_sat;
    end

    ////////////////////////////////////////////////////////////////////////
    // Zero-crossing blanking after each commutation
    // ignore programmed PWM periods
    always_ff @(posedge clk) begin
        if (!rst_b)
            blank_r <= '0;
        else if (commutate_done)
            blank_r <= zero_cross_blank_periods;
        else if (pwm_period_tick && blank_r != '0)
            blank_r <= blank_r - 8'h01;
    end

    ////////////////////////////////////////////////////////////////////////
    // TCP idle timeout
    logic [TO_W-1:0] idle_s_r;
    logic            tcp_drop_r;
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            idle_s_r   <= '0;
            tcp_drop_r <= 1'b0;
        end else if (link_activity || tcp_idle_timeout_s == '0) begin
            idle_s_r   <= '0;
            tcp_drop_r <= 1'b0;
        end else if (s_tick) begin
            tcp_drop_r <= (idle_s_r + 32'h1 >= tcp_idle_timeout_s);
            idle_s_r   <= (idle_s_r + 32'h1 >= tcp_idle_timeout_s)
                        ? '0 : idle_s_r + 32'h1;
        end else begin
            tcp_drop_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Status outputs
    logic [1:0] run_r;
    always_ff @(posedge clk) begin
        if (!rst_b)
            run_r <= RUN_STOPPED;
        else if (state_nxt == SS_CLOSE)
            run_r <= RUN_RUNNING;
        else if (state_nxt == SS_IDLE)
            run_r <= RUN_STOPPED;
        else
            run_r <= RUN_ACCEL;
    end

    logic drv_r;
    logic cl_r;
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            drv_r <= 1'b0;
            cl_r  <= 1'b0;
        end else begin
            drv_r <= !inhibit && (state_nxt == SS_HOLD
                  || state_nxt == SS_RAMP || state_nxt == SS_CLOSE);
            cl_r  <= !inhibit && (state_nxt == SS_CLOSE);
        end
    end

    assign drive_run_state   = run_r;
    assign drive_enable      = drv_r && !inhibit;
    assign closed_loop       = cl_r;
    assign commutation_rpm   = rpm_r;
    assign zero_cross_search = cl_r && (blank_r == '0);
    assign tcp_drop          = tcp_drop_r;
    assign fw_version_number = FW_VERSION;

endmodule : ssfc_top

`default_nettype wire

// ===== sim/ssfc_top_sva.sv
// Port-level checks of the startup and fault block
`timescale 1ns/1ps
`default_nettype none
module ssfc_top_sva
    import ssfc_pkg::*;
(
    input wire logic              clk,
    input wire logic              rst_b,
    input wire logic              fault_flags_wr,
    input wire logic [FAULT_W-1:0] fault_flags,
    input wire logic [FAULT_W-1:0] fault_events,
    input wire logic [TEMP_W-1:0] ambient_c,
    input wire logic [TEMP_W-1:0] temp_limit_c,
    input wire logic              drive_enable,
    input wire logic [1:0]        drive_run_state,
    input wire logic [MV_W-1:0]   back_emf_mv,
    input wire logic [MV_W-1:0]   spin_down_threshold_mv,
    input wire logic              local_control_enable,
    input wire logic              local_start,
    input wire logic              eth_start,
    input wire logic              eth_stop,
    input wire logic [DUTY_W-1:0] pwm_duty,
    input wire logic              closed_loop
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    // Flags never drop without a write
    property p_sticky; !fault_flags_wr |=>
        (fault_flags & $past(fault_flags)) == $past(fault_flags); endproperty
    a_sticky: assert property (p_sticky)
        else $error("fault flag dropped without write");
    // Quiet write empties the word
    property p_clear; fault_flags_wr && fault_events == '0 &&
        ambient_c <= temp_limit_c |=> fault_flags == '0; endproperty
    a_clear: assert property (p_clear)
        else $error("fault write did not clear");
    // Each event lands on its own bit
    property p_set; fault_events != '0 |=>
        (fault_flags & $past(fault_events)) == $past(fault_events); endproperty
    a_set: assert property (p_set)
        else $error("fault event not latched");
    // Too hot: flag and drive off next edge
    property p_temp; ambient_c > temp_limit_c |=>
        fault_flags[FLT_TEMP] && !drive_enable; endproperty
    a_temp: assert property (p_temp)
        else $error("overtemperature not handled");
    // Interlock, combinational
    property p_inhibit; fault_flags != '0 |-> !drive_enable; endproperty
    a_inhibit: assert property (p_inhibit)
        else $error("drive enabled with fault");
    // Rotor still coasting: stay off
    property p_spin; drive_run_state == RUN_ACCEL && !drive_enable &&
        back_emf_mv > spin_down_threshold_mv |=> !drive_enable; endproperty
    a_spin: assert property (p_spin)
        else $error("drive started while spinning");
    // Disabled front panel is ignored
    property p_local; !local_control_enable && local_start && !eth_start &&
        drive_run_state == RUN_STOPPED |=> drive_run_state == RUN_STOPPED;
    endproperty
    a_local: assert property (p_local)
        else $error("local start while disabled");
    // Remote stop always lands
    property p_stop; eth_stop |=> drive_run_state == RUN_STOPPED &&
        pwm_duty == '0 && !closed_loop; endproperty
    a_stop: assert property (p_stop)
        else $error("remote stop ignored");
endmodule : ssfc_top_sva
`default_nettype wire

// ===== sim/ssfc_bridge_model.sv
// Behavioural inverter stage: PWM period and commutation pulses
`timescale 1ns/1ps
`default_nettype none
module ssfc_bridge_model (
    input  wire logic        clk,
    input  wire logic        drive_enable,
    input  wire logic [15:0] coast_mv,
    output logic             pwm_period_tick,
    output logic             commutate_done,
    output logic [15:0]      back_emf_mv
);
    logic [3:0] div_r  = 4'h0;
    logic [2:0] cnt_r  = 3'h0;
    logic       tick_r = 1'b0;
    logic       done_r = 1'b0;
    // PWM runs free; commutation a cycle after a tick so they never meet
    always_ff @(posedge clk) begin
        div_r  <= (div_r == 4'h9) ? 4'h0 : div_r + 4'h1;
        tick_r <= (div_r == 4'h9);
        cnt_r  <= tick_r ? cnt_r + 3'h1 : cnt_r;
        done_r <= drive_enable && tick_r && (cnt_r == 3'h7);
    end
    // Coasting rotor level comes from the bench
    assign back_emf_mv     = coast_mv;
    assign pwm_period_tick = tick_r;
    assign commutate_done  = done_r;
endmodule : ssfc_bridge_model
`default_nettype wire

// ===== sim/tb.sv
// Self-checking bench for the startup and fault block
`timescale 1ns/1ps
`default_nettype none
module tb;
    import ssfc_pkg::*;
    localparam logic [15:0] FWV = 16'hA5C3; // Arbitrary value
    typedef struct packed {logic [7:0] ev; logic [6:0] amb; logic [7:0] ex;}
        ssfc_row_t;
    logic        clk = 1'b0;
    logic        rst_b = 1'b0;
    logic [15:0] hold_time_ms = 16'h0001, open_loop_ramp_ms = 16'h0001;
    logic [15:0] open_loop_begin_rpm = 16'h0190, open_loop_end_rpm = 16'h03E8;
    logic [15:0] open_loop_begin_mv = 16'h04B0, open_loop_end_mv = 16'h0E10;
    logic [15:0] spin_down_threshold_mv = 16'h01F4, bus_mv = 16'h1770;
    logic [15:0] coast_mv = 16'h07D0, back_emf_mv, pwm_duty;
    logic [15:0] commutation_rpm, fw_version_number;
    logic [7:0]  zero_cross_blank_periods = 8'h03, fault_events = 8'h00;
    logic [7:0]  fault_flags;
    logic [31:0] tcp_idle_timeout_s = 32'h1;
    logic [6:0]  temp_limit_c = 7'h55, ambient_c = 7'h19;
    logic        fault_flags_wr = 1'b0, eth_start = 1'b0, eth_stop = 1'b0;
    logic        local_start = 1'b0, local_stop = 1'b0, link_activity = 1'b0;
    logic        local_control_enable = 1'b0;
    logic        pwm_period_tick, commutate_done, drive_enable, closed_loop;
    logic        zero_cross_search, tcp_drop;
    logic [1:0]  drive_run_state;
    int          error_cnt = 0, check_count = 0, n, k;
    // Fault rows: event, ambient, expected word; last two test the limit
    ssfc_row_t rows [10] = '{{8'h01, 7'h19, 8'h01}, {8'h02, 7'h19, 8'h02},
        {8'h04, 7'h19, 8'h04}, {8'h08, 7'h19, 8'h08}, {8'h10, 7'h19, 8'h10},
        {8'h20, 7'h19, 8'h20}, {8'h40, 7'h19, 8'h40}, {8'h80, 7'h19, 8'h80},
        {8'h00, 7'h56, 8'h40}, {8'h00, 7'h55, 8'h00}};

    always #10 clk = ~clk;

    ssfc_top #(.FW_VERSION(FWV)) ssfc_top_inst (.clk, .rst_b, .hold_time_ms,
        .zero_cross_blank_periods, .open_loop_begin_rpm, .open_loop_end_rpm,
        .open_loop_begin_mv, .open_loop_end_mv, .open_loop_ramp_ms,
        .spin_down_threshold_mv, .tcp_idle_timeout_s, .temp_limit_c,
        .local_control_enable, .fault_flags_wr, .fault_flags,
        .drive_run_state, .fw_version_number, .eth_start, .eth_stop,
        .local_start, .local_stop, .back_emf_mv, .bus_mv, .ambient_c,
        .fault_events, .pwm_period_tick, .commutate_done, .link_activity,
        .drive_enable, .pwm_duty, .commutation_rpm, .closed_loop,
        .zero_cross_search, .tcp_drop);
    ssfc_bridge_model ssfc_bridge_model_inst (.clk, .drive_enable, .coast_mv,
        .pwm_period_tick, .commutate_done, .back_emf_mv);

    task automatic step(input int c);
        repeat (c) @(posedge clk);
        #1;
    endtask : step
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: got %0h want %0h", $time, got, exp);
        end
    endtask : chk
    // One-cycle strobe, then a free edge before any reuse
    task automatic pulse(ref logic s);
        s = 1'b1;
        step(1);
        s = 1'b0;
        step(1);
    endtask : pulse
    task automatic complete_run;
        if (error_cnt == 0 && check_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : complete_run

    ////////////////////////////////////////////////////////////////////////
    // Hang guard: one startup needs at most about two ms
    initial begin
        repeat (140000) @(posedge clk);
        error_cnt++;
        $display("CHECK FAILED at %0t: run timed out", $time);
        complete_run();
    end

    initial begin
        step(16);
        chk(drive_run_state, RUN_STOPPED);
        chk(fw_version_number, FWV);
        rst_b = 1'b1;
        step(1);
        for (k = 0; k < 10; k++) begin
            fault_events = rows[k].ev;
            ambient_c = rows[k].amb;
            step(1);
            fault_events = 8'h00;
            ambient_c = 7'h19;
            step(2);
            chk(fault_flags, rows[k].ex);
            pulse(fault_flags_wr);
            chk(fault_flags, 8'h00);
        end
        // Start refused while a fault stands
        fault_events = 8'h10;
        step(1);
        fault_events = 8'h00;
        pulse(eth_start);
        chk(drive_run_state, RUN_STOPPED);
        pulse(fault_flags_wr);
        pulse(local_start);
        chk(drive_run_state, RUN_STOPPED);
        local_control_enable = 1'b1;
        pulse(local_start);
        chk(drive_run_state, RUN_ACCEL);
        step(20);
        chk(drive_enable, 1'b0);
        pulse(local_stop);
        chk(drive_run_state, RUN_STOPPED);
        local_control_enable = 1'b0;
        // Remote start while rotor coasts above threshold: drive stays off
        pulse(eth_start);
        step(8);
        chk(drive_enable, 1'b0);
        // Disabled panel stop ignored, remote stop lands, restart
        pulse(local_stop);
        chk(drive_run_state, RUN_ACCEL);
        pulse(eth_stop);
        chk(drive_run_state, RUN_STOPPED);
        pulse(eth_start);
        coast_mv = 16'h01F4;
        for (n = 0; n < 10 && drive_enable !== 1'b1; n++) step(1);
        // Duty register follows the hold state one edge later
        step(1);
        chk(pwm_duty, 16'h3333);
        for (n = 0; n < 110000 && closed_loop !== 1'b1; n++) step(1);
        chk(n > 50000 && n < 100010, 1);
        chk(commutation_rpm, 16'h03E8);
        step(1);
        chk(pwm_duty, 16'h9999);
        chk(drive_run_state, RUN_RUNNING);
        // Blanking after a commutation, counted in PWM ticks
        for (n = 0; n < 200 && commutate_done !== 1'b1; n++) step(1);
        step(1);
        k = 0;
        for (n = 0; n < 200 && zero_cross_search !== 1'b1; n++) begin
            if (pwm_period_tick === 1'b1) k++;
            step(1);
        end
        chk(k, 3);
        bus_mv = 16'h0BB8;
        step(3);
        chk(pwm_duty, 16'hFFFF);
        ambient_c = 7'h56;
        step(1);
        chk(fault_flags, 8'h40);
        chk(drive_enable, 1'b0);
        ambient_c = 7'h19;
        step(2);
        chk(drive_run_state, RUN_STOPPED);
        chk(pwm_duty, 16'h0000);
        pulse(fault_flags_wr);
        // One-second timeout cannot expire within this short run
        chk(tcp_drop, 1'b0);
        complete_run();
    end
endmodule : tb

bind ssfc_top ssfc_top_sva ssfc_top_sva_inst (.clk, .rst_b, .fault_flags_wr,
    .fault_flags, .fault_events, .ambient_c, .temp_limit_c, .drive_enable,
    .drive_run_state, .back_emf_mv, .spin_down_threshold_mv,
    .local_control_enable, .local_start, .eth_start, .eth_stop, .pwm_duty,
    .closed_loop);
`default_nettype wire
